// ==== verification/port_b_alternate_function_mux_bench.sv ====
/*
 Self-checking bench for the port B alternate-function mux.
 Assumes the design answers Wishbone and registers every pad output.
*/
`timescale 1ns/1ns
`default_nettype none
`include "port_b_consts.svh"

module port_b_alternate_function_mux_bench
    import port_b_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    logic [3:0] tmr_en = 4'h0;
    logic [3:0] tmr_val = 4'h0;
    logic spi_so = 1'b0;
    logic spi_mo = 1'b0;
    logic spi_sck = 1'b0;
    logic sleep = 1'b0;
    logic [7:0] ext_oe = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq, spi_master_in, spi_slave_in, spi_sck_in;
    logic spi_select_n;
    logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, pad_input_en;
    logic [7:0] pin_change_src;
    int fails = 0;
    int checked = 0;

    always #25 clk_sys = ~clk_sys;

    port_b_alt_mux i_port_b_alt_mux (.clk_sys(clk_sys), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq(irq),
        .timer2_compare_a_out(tmr_val[3]), .timer2_compare_a_en(tmr_en[3]),
        .timer1_compare_b_out(tmr_val[2]), .timer1_compare_b_en(tmr_en[2]),
        .timer1_compare_a_out(tmr_val[1]), .timer1_compare_a_en(tmr_en[1]),
        .timer0_compare_a_out(tmr_val[0]), .timer0_compare_a_en(tmr_en[0]),
        .spi_slave_out(spi_so), .spi_master_out(spi_mo),
        .spi_sck_out(spi_sck), .sleep_active(sleep), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .pad_input_en(pad_input_en), .pin_change_src(pin_change_src),
        .spi_master_in(spi_master_in), .spi_slave_in(spi_slave_in),
        .spi_sck_in(spi_sck_in), .spi_select_n(spi_select_n));

    port_b_pads_model i_port_b_pads_model (.clk_sys(clk_sys),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .ext_oe(ext_oe), .ext_val(ext_val), .pad_in(pad_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        check(wb_ack_o, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00);
        check(rd, exp);
    endtask : rdchk

    // Outputs lag one cycle behind the pad model's own register stage
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic t_regs;
        logic [7:0] ofs [7];
        ofs = '{`OFS_DIR, `OFS_OUT, `OFS_CTRL, `OFS_PCMASK,
            `OFS_IRQ_STAT, `OFS_IRQ_MASK, 8'h1C};
        wb(1'b1, 8'h1C, 8'hFF);
        foreach (ofs[i])
            rdchk(ofs[i], 32'h0);
    endtask : t_regs

    task automatic t_cmp;
        logic [3:0] m;
        logic [3:0] x;
        wb(1'b1, `OFS_DIR, 8'h00);
        tmr_en <= 4'hF;
        tmr_val <= 4'hF;
        settle;
        check(pad_oe[7:4], 4'h0);
        wb(1'b1, `OFS_DIR, 8'hF0);
        for (int v = 0; v < 2; v++)
        begin
            wb(1'b1, `OFS_OUT, v ? 8'h00 : 8'hF0);
            for (int i = 0; i < 5; i++)
            begin
                m = 4'(1 << i);
                @(posedge clk_sys);
                tmr_en <= m;
                tmr_val <= v ? 4'hF : 4'h0;
                x = v ? m : ~m;
                settle;
                check(pad_out[7:4], x);
                check(pad_oe[7:4], 4'hF);
            end
        end
    endtask : t_cmp

    task automatic t_master;
        wb(1'b1, `OFS_OUT, 8'h08);
        wb(1'b1, `OFS_DIR, 8'h0F);
        wb(1'b1, `OFS_CTRL, 8'h06);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge clk_sys);
            spi_mo <= v[0];
            spi_sck <= ~v[0];
            settle;
            check(pad_oe[3:0], 4'h7);
            check(pad_out[2:1], {v[0], ~v[0]});
            check(pad_pullup[3], 1'b1);
        end
        wb(1'b1, `OFS_CTRL, 8'h07);
        settle;
        check(pad_pullup[3], 1'b0);
    endtask : t_master

    task automatic t_slave;
        logic [3:0] e;
        wb(1'b1, `OFS_OUT, 8'h07);
        wb(1'b1, `OFS_CTRL, 8'h02);
        ext_oe <= 8'h07;
        for (int v = 0; v < 2; v++)
        begin
            e = v ? 4'hD : 4'h2;
            @(posedge clk_sys);
            ext_val <= {4'h0, e};
            spi_so <= e[3];
            settle;
            check(pad_oe[3:0], 4'h8);
            check(pad_pullup[2:0], 3'h7);
            check(pad_out[3], e[3]);
            check({spi_master_in, spi_slave_in, spi_sck_in, spi_select_n},
                e);
            check(pin_change_src[3:0], e);
        end
    endtask : t_slave

    task automatic t_irq;
        wb(1'b1, `OFS_CTRL, 8'h08);
        wb(1'b1, `OFS_DIR, 8'h00);
        wb(1'b1, `OFS_PCMASK, 8'h01);
        wb(1'b1, `OFS_IRQ_MASK, 8'h01);
        ext_oe <= 8'hFF;
        ext_val <= 8'h00;
        sleep <= 1'b1;
        settle;
        wb(1'b1, `OFS_IRQ_STAT, 8'hFF);
        settle;
        check(irq, 1'b0);
        check(pad_input_en, 8'h01);
        @(posedge clk_sys);
        ext_val <= 8'h03;
        settle;
        check(irq, 1'b1);
        rdchk(`OFS_IRQ_STAT, 32'h1);
        rdchk(`OFS_PIN, 32'h3);
        wb(1'b1, `OFS_IRQ_MASK, 8'h00);
        settle;
        check(irq, 1'b0);
        wb(1'b1, `OFS_IRQ_STAT, 8'h01);
        rdchk(`OFS_IRQ_STAT, 32'h0);
        sleep <= 1'b0;
        settle;
        check(pad_input_en, 8'hFF);
    endtask : t_irq

    task automatic t_pull;
        wb(1'b1, `OFS_CTRL, 8'h00);
        wb(1'b1, `OFS_OUT, 8'hFF);
        ext_oe <= 8'h00;
        settle;
        check(pad_pullup, 8'hFF);
        wb(1'b1, `OFS_CTRL, 8'h01);
        settle;
        check(pad_pullup, 8'h00);
        wb(1'b1, `OFS_CTRL, 8'h00);
        wb(1'b1, `OFS_DIR, 8'hFF);
        settle;
        check(pad_pullup, 8'h00);
        check(pad_out, 8'hFF);
    endtask : t_pull

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // Whole run needs well under a thousand cycles
    initial
    begin
        #200000;
        fails++;
        give_verdict;
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs;
        t_cmp;
        t_master;
        t_slave;
        t_irq;
        t_pull;
        give_verdict;
    end
endmodule : port_b_alternate_function_mux_bench
`default_nettype wire

// ==== verification/port_b_pads_model.sv ====
/*
 Pad model for the port B mux: resolves each pad level every cycle.
 Assumes the bench drives ext_oe and ext_val on rising edges of clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none

module port_b_pads_model
(
    input wire logic clk_sys,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] ext_oe,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    // A floating pad flips each cycle, so a stale level never passes
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pad_oe[i] === 1'b1)
                pad_in[i] <= pad_out[i];
            else if (ext_oe[i])
                pad_in[i] <= ext_val[i];
            else if (pad_pullup[i] === 1'b1)
                pad_in[i] <= 1'b1;
            else if (pad_in[i] === 1'b1)
                pad_in[i] <= 1'b0;
            else
                pad_in[i] <= 1'b1;
        end
    end
endmodule : port_b_pads_model
`default_nettype wire

// ==== verilog/port_b_alt_mux.sv ====
/*
 Port B alternate-function mux: compare outputs on bits 7..4, serial
 interface on bits 3..0, pin-change sources on all bits, with a
 Wishbone register file and a pin-change interrupt.
 Assumes pads, timers and serial unit are synchronous to clk_sys.
*/
// The address map and register access over Wishbone were chosen for this implementation.
// Overview of operation
// [RULE1] Timer2 compare A drives bit 7
// [RULE2] Compare outputs need direction bit set
// [RULE3] Timer1 compare B drives bit 6
// [RULE4] Timer1 compare A drives bit 5
// [RULE5] Timer0 compare A drives bit 4
// [RULE6] Masked pin change forces input enable
// [RULE7] Master mode forces bit 3 input
// [RULE8] Slave mode forces bit 2 input
// [RULE9] Slave mode forces bit 1 input
// [RULE10] Slave mode forces bit 0 input
// [RULE11] Low select pin activates slave interface
// [RULE12] Forced-input pull-up follows output bit
// [RULE13] Bit 3 carries slave out, master in
// [RULE14] Bit 2 carries master out, slave in
// [RULE15] Bit 1 carries serial clock both ways
// [RULE16] Pull-up override else default 010 pattern
// [RULE17] Value reaches pad only when driving
// [RULE18] Input enable override else sleep state
// [RULE19] Raw pad input shared by all users
`timescale 1ns/1ns
`default_nettype none
`include "port_b_consts.svh"

module port_b_alt_mux
    import port_b_pkg::*;
#(
    parameter int WB_ADR_W = 8
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic timer2_compare_a_out,
    input wire logic timer2_compare_a_en,
    input wire logic timer1_compare_b_out,
    input wire logic timer1_compare_b_en,
    input wire logic timer1_compare_a_out,
    input wire logic timer1_compare_a_en,
    input wire logic timer0_compare_a_out,
    input wire logic timer0_compare_a_en,
    input wire logic spi_slave_out,
    input wire logic spi_master_out,
    input wire logic spi_sck_out,
    input wire logic sleep_active,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pullup,
    output logic [7:0] pad_input_en,
    output logic [7:0] pin_change_src,
    output logic spi_master_in,
    output logic spi_slave_in,
    output logic spi_sck_in,
    output logic spi_select_n
);

    generate
        if (WB_ADR_W < `MIN_ADR_W)
        begin : g_bad_adr
            $error("WB_ADR_W too small for register map");
        end
    endgenerate

    state_type r;
    state_type n;

    logic [7:0] off;
    logic wr;
    logic spi_m;
    logic spi_s;
    logic pu_disable;
    logic [7:0] pullup_ovr_en;
    logic [7:0] pullup_ovr_val;
    logic [7:0] direction_ovr_en;
    logic [7:0] value_ovr_en;
    logic [7:0] value_ovr_val;
    logic [7:0] input_en_ovr_en;
    logic [7:0] oe;
    logic [7:0] chg;
    logic [7:0] clr;

    // Per-bit override select used for every pad attribute
    function automatic logic [7:0] ovr(
        input logic [7:0] en,
        input logic [7:0] val,
        input logic [7:0] base
    );
        ovr = (en & val) | (~en & base);
    endfunction : ovr

    function automatic logic [31:0] reg_read(
        input state_type s,
        input logic [7:0] a
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `OFS_DIR: v = s.dir;
            `OFS_OUT: v = s.out;
            `OFS_CTRL: v = {4'h0, s.ctrl};
            `OFS_PCMASK: v = s.pcmask;
            `OFS_PIN: v = s.pin_change_src;
            `OFS_IRQ_STAT: v = s.irq_status;
            `OFS_IRQ_MASK: v = s.irq_mask;
            default: v = 8'h00;
        endcase
        reg_read = {24'h000000, v};
    endfunction : reg_read

    always_comb
    begin
        n = r;
        off = {wb_adr_i[7:2], 2'b00};
        // Ack one cycle after the request; the write commits at the
        // edge where the master samples ack high
        n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        wr = wb_cyc_i & wb_stb_i & wb_we_i & r.ack & wb_sel_i[0];
        if (n.ack)
        begin
            n.dat = reg_read(r, off);
        end
        clr = 8'h00;
        if (wr)
        begin
            case (off)
                `OFS_DIR: n.dir = wb_dat_i[7:0];
                `OFS_OUT: n.out = wb_dat_i[7:0];
                `OFS_CTRL: n.ctrl = wb_dat_i[3:0];
                `OFS_PCMASK: n.pcmask = wb_dat_i[7:0];
                `OFS_IRQ_STAT: clr = wb_dat_i[7:0];
                `OFS_IRQ_MASK: n.irq_mask = wb_dat_i[7:0];
                default: clr = 8'h00;
            endcase
        end

        pu_disable = r.ctrl[`CTRL_PULLUP_DIS];
        spi_m = r.ctrl[`CTRL_SER_EN] & r.ctrl[`CTRL_SER_MASTER];
        spi_s = r.ctrl[`CTRL_SER_EN] & ~r.ctrl[`CTRL_SER_MASTER];

        // Only serial pins force direction; compare pins never do
        direction_ovr_en = {4'h0,
            spi_m, // RULE7
            spi_s, spi_s, spi_s}; // RULE2 RULE8 RULE9 RULE10
        pullup_ovr_en = direction_ovr_en;
        pullup_ovr_val = r.out & ~{8{pu_disable}}; // RULE12
        value_ovr_en = {timer2_compare_a_en, timer1_compare_b_en,
            timer1_compare_a_en, timer0_compare_a_en,
            spi_s, spi_m, spi_m, 1'b0}; // RULE10
        value_ovr_val = {timer2_compare_a_out, // RULE1
            timer1_compare_b_out, // RULE3
            timer1_compare_a_out, // RULE4
            timer0_compare_a_out, // RULE5
            spi_slave_out, // RULE13
            spi_master_out, // RULE14
            spi_sck_out, // RULE15
            1'b0};
        input_en_ovr_en = r.pcmask & {8{r.ctrl[`CTRL_PCGE]}}; // RULE6

        oe = ovr(direction_ovr_en, 8'h00, r.dir);
        n.pad_oe = oe;
        // Value is gated by the driver so an undriven pad reads as 0
        n.pad_out = ovr(value_ovr_en, value_ovr_val, r.out) & oe; // RULE17
        n.pad_pullup = ovr(pullup_ovr_en, pullup_ovr_val,
            ~r.dir & r.out & ~{8{pu_disable}}); // RULE16
        n.pad_input_en = ovr(input_en_ovr_en, 8'hFF,
            {8{~sleep_active}}); // RULE18

        n.pin_change_src = pad_in; // RULE19
        n.spi_master_in = pad_in[3]; // RULE13
        n.spi_slave_in = pad_in[2]; // RULE14
        n.spi_sck_in = pad_in[1]; // RULE15
        n.spi_select_n = pad_in[0]; // RULE11

        // Pin-change events; a new event beats a same-cycle clear
        chg = (pad_in ^ r.pad_prev) & input_en_ovr_en;
        n.pad_prev = pad_in;
        n.irq_status = (r.irq_status & ~clr) | chg;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.dir <= `RST_BYTE;
            r.out <= `RST_BYTE;
            r.ctrl <= `RST_CTRL;
            r.irq_mask <= `RST_BYTE;
        end
        else
        begin
            r <= n;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.dat;
    assign irq = |(r.irq_status & r.irq_mask);
    assign pad_out = r.pad_out;
    assign pad_oe = r.pad_oe;
    assign pad_pullup = r.pad_pullup;
    assign pad_input_en = r.pad_input_en;
    assign pin_change_src = r.pin_change_src;
    assign spi_master_in = r.spi_master_in;
    assign spi_slave_in = r.spi_slave_in;
    assign spi_sck_in = r.spi_sck_in;
    assign spi_select_n = r.spi_select_n;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_m_mode;
        r.ctrl[`CTRL_SER_EN] && r.ctrl[`CTRL_SER_MASTER];
    endsequence

    sequence s_s_mode;
        r.ctrl[`CTRL_SER_EN] && !r.ctrl[`CTRL_SER_MASTER];
    endsequence

    sequence s_wr_ctrl;
        wb_cyc_i && wb_stb_i && wb_we_i && r.ack && wb_sel_i[0]
            && off == `OFS_CTRL;
    endsequence

    property p_cmp7;
        r.dir[7] && timer2_compare_a_en
            |=> pad_out[7] == $past(timer2_compare_a_out);
    endproperty
    a_cmp7: assert property (p_cmp7) // RULE1
        else $error("bit 7 not carrying timer2 compare A");

    property p_cmp_dir;
        !r.dir[7] && timer2_compare_a_en |=> !pad_oe[7] && !pad_out[7];
    endproperty
    a_cmp_dir: assert property (p_cmp_dir) // RULE2
        else $error("compare output drove pad with direction clear");

    property p_cmp6;
        r.dir[6] && timer1_compare_b_en
            |=> pad_out[6] == $past(timer1_compare_b_out);
    endproperty
    a_cmp6: assert property (p_cmp6) // RULE3
        else $error("bit 6 not carrying timer1 compare B");

    property p_cmp5;
        r.dir[5] && timer1_compare_a_en
            |=> pad_out[5] == $past(timer1_compare_a_out);
    endproperty
    a_cmp5: assert property (p_cmp5) // RULE4
        else $error("bit 5 not carrying timer1 compare A");

    property p_cmp4;
        r.dir[4] && timer0_compare_a_en
            |=> pad_out[4] == $past(timer0_compare_a_out);
    endproperty
    a_cmp4: assert property (p_cmp4) // RULE5
        else $error("bit 4 not carrying timer0 compare A");

    property p_die;
        r.ctrl[`CTRL_PCGE] |=> (pad_input_en & $past(r.pcmask))
            == $past(r.pcmask);
    endproperty
    a_die: assert property (p_die) // RULE6
        else $error("pin-change bit without input enable");

    property p_miso_in;
        s_m_mode |=> !pad_oe[3];
    endproperty
    a_miso_in: assert property (p_miso_in) // RULE7
        else $error("bit 3 driven while master");

    property p_slave_in;
        s_s_mode |=> pad_oe[2:0] == 3'b000;
    endproperty
    a_slave_in: assert property (p_slave_in) // RULE8 RULE9 RULE10
        else $error("bits 2..0 driven while slave");

    property p_select;
        // Sampled reset keeps the release edge out of the check
        rst_n |=> spi_select_n == $past(pad_in[0]);
    endproperty
    a_select: assert property (p_select) // RULE11
        else $error("select input not routed from bit 0");

    property p_pu_forced;
        s_s_mode ##1 s_s_mode |-> pad_pullup[2:0]
            == ($past(r.out[2:0]) & ~{3{$past(r.ctrl[`CTRL_PULLUP_DIS])}});
    endproperty
    a_pu_forced: assert property (p_pu_forced) // RULE12
        else $error("forced-input pull-up wrong");

    property p_pu_master;
        s_m_mode |=> pad_pullup[3]
            == ($past(r.out[3]) && !$past(r.ctrl[`CTRL_PULLUP_DIS]));
    endproperty
    a_pu_master: assert property (p_pu_master) // RULE12
        else $error("bit 3 pull-up wrong while master");

    property p_miso_out;
        (s_s_mode and r.dir[3]) |=> pad_out[3] == $past(spi_slave_out)
            && spi_master_in == $past(pad_in[3]);
    endproperty
    a_miso_out: assert property (p_miso_out) // RULE13
        else $error("bit 3 slave output wrong");

    property p_mosi;
        (s_m_mode and r.dir[2]) |=> pad_out[2] == $past(spi_master_out)
            && spi_slave_in == $past(pad_in[2]);
    endproperty
    a_mosi: assert property (p_mosi) // RULE14
        else $error("bit 2 master output wrong");

    property p_sck;
        (s_m_mode and r.dir[1]) |=> pad_out[1] == $past(spi_sck_out)
            && spi_sck_in == $past(pad_in[1]);
    endproperty
    a_sck: assert property (p_sck) // RULE15
        else $error("bit 1 serial clock wrong");

    property p_pu_plain;
        !r.ctrl[`CTRL_SER_EN] |=> pad_pullup[7:4] == (~$past(r.dir[7:4])
            & $past(r.out[7:4]) & ~{4{$past(r.ctrl[`CTRL_PULLUP_DIS])}});
    endproperty
    a_pu_plain: assert property (p_pu_plain) // RULE16
        else $error("default pull-up pattern wrong");

    property p_undriven;
        !pad_oe[7] |-> !pad_out[7];
    endproperty
    a_undriven: assert property (p_undriven) // RULE17
        else $error("value on pad with driver off");

    property p_sleep;
        sleep_active && !r.ctrl[`CTRL_PCGE] |=> pad_input_en == 8'h00;
    endproperty
    a_sleep: assert property (p_sleep) // RULE18
        else $error("input enable ignores sleep");

    property p_shared;
        1'b1 |-> pin_change_src[3:0] == {spi_master_in, spi_slave_in,
            spi_sck_in, spi_select_n};
    endproperty
    a_shared: assert property (p_shared) // RULE19
        else $error("pad input differs between users");

    property p_ctrl_wr;
        s_wr_ctrl |=> r.ctrl == $past(wb_dat_i[3:0]) ##1 !wb_ack_o;
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("control write not stored or ack held");

    property p_irq_set;
        (|chg) |=> (r.irq_status & $past(chg)) == $past(chg);
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("pin-change event lost");

endmodule : port_b_alt_mux
`default_nettype wire

// ==== verilog/port_b_consts.svh ====
/*
 Register offsets, field positions, reset values for the port B
 alternate-function mux. Assumes byte addresses on a 32-bit Wishbone.
*/
`ifndef PORT_B_CONSTS_SVH
`define PORT_B_CONSTS_SVH

`define OFS_DIR 8'h00
`define OFS_OUT 8'h04
`define OFS_CTRL 8'h08
`define OFS_PCMASK 8'h0C
`define OFS_PIN 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18

`define CTRL_PULLUP_DIS 0
`define CTRL_SER_EN 1
`define CTRL_SER_MASTER 2
`define CTRL_PCGE 3

`define RST_BYTE 8'h00
`define RST_CTRL 4'h0
`define MIN_ADR_W 8

`endif

// ==== verilog/port_b_pkg.sv ====
/*
 Types for the port B alternate-function mux.
 Assumes the constants header is included by the user.
*/
`default_nettype none
package port_b_pkg;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] out;
        logic [3:0] ctrl;
        logic [7:0] pcmask;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [7:0] pad_prev;
        logic ack;
        logic [31:0] dat;
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
        logic [7:0] pad_pullup;
        logic [7:0] pad_input_en;
        logic [7:0] pin_change_src;
        logic spi_master_in;
        logic spi_slave_in;
        logic spi_sck_in;
        logic spi_select_n;
    } state_type;

endpackage : port_b_pkg
`default_nettype wire
